// ### sbst_pkg.sv
package sbst_pkg;
  localparam logic [2:0] SBST_IR_EXTEST   = 3'h0;
  localparam logic [2:0] SBST_IR_IDREAD   = 3'h1;
  localparam logic [2:0] SBST_IR_HIZ_SAMP = 3'h2;
  localparam logic [2:0] SBST_IR_SAMP_PRE = 3'h4;
  localparam logic [2:0] SBST_IR_BYPASS   = 3'h7;
  localparam logic [1:0] SBST_IR_CAPTURE  = 2'h1;
  localparam int         SBST_IR_W        = 3;
  localparam int         SBST_ID_W        = 32;
  localparam int         SBST_RESET_ONES  = 5;
  localparam logic [2:0] SBST_ONES_MAX    = 3'h5;
  localparam logic       SBST_FILLER_VAL  = 1'h1;
  typedef enum {
    SBST_TLR, SBST_RTI, SBST_SEL_DR, SBST_CAP_DR, SBST_SH_DR, SBST_EX1_DR, SBST_PA_DR,
    SBST_EX2_DR, SBST_UPD_DR, SBST_SEL_IR, SBST_CAP_IR, SBST_SH_IR, SBST_EX1_IR,
    SBST_PA_IR, SBST_EX2_IR, SBST_UPD_IR
  } sbst_state_t;
endpackage

// ### sbst_edge_if.sv
`timescale 1ns/100ps
interface sbst_edge_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  modport det (output tck_rise, output tck_fall, output tms, output tdi);
  modport use_side (input tck_rise, input tck_fall, input tms, input tdi);
endinterface

// ### sbst_pin_sync.sv
`timescale 1ns/100ps
module sbst_pin_sync
  import sbst_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Test pins from the far side
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  // Edge events and sampled levels
  sbst_edge_if.det  edge_o
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic       tck_d;
  } sbst_sync_t;
  sbst_sync_t st_reg;
  sbst_sync_t st_next;

  always_comb
  begin
    st_next       = st_reg;
    st_next.s1    = {tck, tms, tdi};
    st_next.s2    = st_reg.s1;
    st_next.tck_d = st_reg.s2[2];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      // Pull-ups: idle pins read as one
      st_reg <= '{s1: 3'h7, s2: 3'h7, tck_d: 1'h1};
    else
      st_reg <= st_next;
  end

  assign edge_o.tck_rise = st_reg.s2[2] & ~st_reg.tck_d;
  assign edge_o.tck_fall = ~st_reg.s2[2] & st_reg.tck_d;
  assign edge_o.tms      = st_reg.s2[1];
  assign edge_o.tdi      = st_reg.s2[0];
endmodule

// ### sbst_tap.sv
// Overview of operation
// - Sample on TCK rise, outputs change on fall except bsr_update, which loads on rise
// - Undriven TMS reads as one
// - Undriven TDI reads as one
// - TDO driven only in shift states
// - Five TMS-high rises reach Test-Logic-Reset
// - Self reset at power-up, idle until clocked
// - One register between TDI and TDO
// - Serial in on rise, out on fall
// - Three-bit instruction, loaded only while selected
// - Instruction acts in idle and data states
// - Identification instruction loaded on reset
// - Bypass is one flip-flop
// - Boundary register captures pins, shifts them out
// - Unbound cells always capture one
// - Only three instructions select boundary register
// - Instruction code decode, unused codes bypass
// - Capture-IR loads 01 into low bits
// - 32-bit identification, shifted LSB first
// - High-impedance sample floats memory outputs
`timescale 1ns/100ps
module sbst_tap
  import sbst_pkg::*;
#(
  parameter int               BSR_LEN   = 8,
  parameter logic [7:0]       BSR_BOUND = 8'h3F,
  parameter logic [31:0]      ID_VALUE  = 32'h0000_0001 // Arbitrary identity value
)
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Test pins
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  // Memory pin levels for capture
  input  wire logic [BSR_LEN-1:0] pin_levels,
  // Memory output control
  output logic                    mem_out_hiz,
  output logic [BSR_LEN-1:0]      bsr_update,
  output logic                    extest_on
);
  typedef struct packed {
    sbst_state_t            fsm;
    logic [SBST_IR_W-1:0]   ir_shift;
    logic [SBST_IR_W-1:0]   ir;
    logic                   bypass;
    logic [SBST_ID_W-1:0]   idr;
    logic [BSR_LEN-1:0]     bsr;
    logic [BSR_LEN-1:0]     upd;
    logic                   tdo;
    logic                   tdo_oe;
    logic                   hiz;
    logic                   extest;
  } sbst_tap_t;
  sbst_tap_t st_reg;
  sbst_tap_t st_next;
  sbst_edge_if ev ();
  logic [BSR_LEN-1:0] cap_val;

  // Two-flop synchronised pins, pulled high during reset
  sbst_pin_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .edge_o   (ev.det)
  );

  genvar g;
  generate
    for (g = 0; g < BSR_LEN; g++)
    begin : g_cell
      // Filler cells ignore their pin
      assign cap_val[g] = BSR_BOUND[g] ? pin_levels[g] : SBST_FILLER_VAL;
    end
  endgenerate

  function automatic sbst_state_t step(input sbst_state_t s, input logic m);
    sbst_state_t n;
    n = s;
    case (s)
      SBST_TLR:    n = m ? SBST_TLR    : SBST_RTI;
      SBST_RTI:    n = m ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_DR: n = m ? SBST_SEL_IR : SBST_CAP_DR;
      SBST_CAP_DR: n = m ? SBST_EX1_DR : SBST_SH_DR;
      SBST_SH_DR:  n = m ? SBST_EX1_DR : SBST_SH_DR;
      SBST_EX1_DR: n = m ? SBST_UPD_DR : SBST_PA_DR;
      SBST_PA_DR:  n = m ? SBST_EX2_DR : SBST_PA_DR;
      SBST_EX2_DR: n = m ? SBST_UPD_DR : SBST_SH_DR;
      SBST_UPD_DR: n = m ? SBST_SEL_DR : SBST_RTI;
      SBST_SEL_IR: n = m ? SBST_TLR    : SBST_CAP_IR;
      SBST_CAP_IR: n = m ? SBST_EX1_IR : SBST_SH_IR;
      SBST_SH_IR:  n = m ? SBST_EX1_IR : SBST_SH_IR;
      SBST_EX1_IR: n = m ? SBST_UPD_IR : SBST_PA_IR;
      SBST_PA_IR:  n = m ? SBST_EX2_IR : SBST_PA_IR;
      SBST_EX2_IR: n = m ? SBST_UPD_IR : SBST_SH_IR;
      SBST_UPD_IR: n = m ? SBST_SEL_DR : SBST_RTI;
      default:     n = SBST_TLR;
    endcase
    return n;
  endfunction

  // Data path choice from the held instruction
  function automatic logic sel_bsr(input logic [2:0] i);
    return (i == SBST_IR_EXTEST) || (i == SBST_IR_HIZ_SAMP) || (i == SBST_IR_SAMP_PRE);
  endfunction

  always_comb
  begin
    st_next = st_reg;
    if (ev.tck_rise)
    begin
      st_next.fsm = step(st_reg.fsm, ev.tms);
      case (st_reg.fsm)
        SBST_TLR:
        begin
          st_next.ir = SBST_IR_IDREAD;
        end
        SBST_CAP_IR:
          st_next.ir_shift = {st_reg.ir[2], SBST_IR_CAPTURE};
        SBST_SH_IR:
          st_next.ir_shift = {ev.tdi, st_reg.ir_shift[2:1]};
        SBST_UPD_IR:
          st_next.ir = st_reg.ir_shift;
        SBST_CAP_DR:
        begin
          if (sel_bsr(st_reg.ir))
            st_next.bsr = cap_val;
          else if (st_reg.ir == SBST_IR_IDREAD)
            st_next.idr = ID_VALUE;
          else
            st_next.bypass = 1'h0;
        end
        SBST_SH_DR:
        begin
          // Only the selected register moves
          if (sel_bsr(st_reg.ir))
            st_next.bsr = {ev.tdi, st_reg.bsr[BSR_LEN-1:1]};
          else if (st_reg.ir == SBST_IR_IDREAD)
            st_next.idr = {ev.tdi, st_reg.idr[SBST_ID_W-1:1]};
          else
            st_next.bypass = ev.tdi;
        end
        SBST_UPD_DR:
          if (sel_bsr(st_reg.ir))
            st_next.upd = st_reg.bsr;
        default:
          st_next.ir = st_reg.ir;
      endcase
    end
    if (ev.tck_fall)
    begin
      // Output end of chain launched on the falling edge
      st_next.tdo_oe = (st_reg.fsm == SBST_SH_DR) || (st_reg.fsm == SBST_SH_IR);
      if (st_reg.fsm == SBST_SH_IR)
        st_next.tdo = st_reg.ir_shift[0];
      else if (sel_bsr(st_reg.ir))
        st_next.tdo = st_reg.bsr[0];
      else if (st_reg.ir == SBST_IR_IDREAD)
        st_next.tdo = st_reg.idr[0];
      else
        st_next.tdo = st_reg.bypass;
      st_next.hiz    = (st_reg.ir == SBST_IR_HIZ_SAMP) && (st_reg.fsm != SBST_TLR);
      st_next.extest = (st_reg.ir == SBST_IR_EXTEST) && (st_reg.fsm != SBST_TLR);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      // Power-up reset of the controller
      st_reg        <= '0;
      st_reg.fsm    <= SBST_TLR;
      st_reg.ir     <= SBST_IR_IDREAD;
      st_reg.bypass <= 1'h0;
    end
    else
      st_reg <= st_next;
  end

  assign tdo         = st_reg.tdo;
  assign tdo_oe      = st_reg.tdo_oe;
  assign mem_out_hiz = st_reg.hiz;
  assign bsr_update  = st_reg.upd;
  assign extest_on   = st_reg.extest;

  // Helper: count rising edges with TMS high
  logic [2:0] ones_cnt;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      ones_cnt <= 3'h0;
    else if (ev.tck_rise)
      ones_cnt <= ev.tms ? ((ones_cnt == SBST_ONES_MAX) ? ones_cnt : ones_cnt + 3'h1) : 3'h0;
  end

  chk_five_ones_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ones_cnt == SBST_ONES_MAX) |-> (st_reg.fsm == SBST_TLR))
    else $error("five TMS ones did not reach reset");
  chk_tlr_loads_id: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.tck_rise && st_reg.fsm == SBST_TLR) |=> (st_reg.ir == SBST_IR_IDREAD))
    else $error("reset state did not load identification code");
  chk_capir_pattern: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.tck_rise && st_reg.fsm == SBST_CAP_IR) |=> (st_reg.ir_shift[1:0] == SBST_IR_CAPTURE))
    else $error("capture-IR pattern wrong");
  chk_tdo_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_reg.tdo_oe) |-> $past(ev.tck_fall))
    else $error("TDO enabled off a falling edge");
  chk_tdo_fall_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.tdo != $past(st_reg.tdo)) |-> $past(ev.tck_fall))
    else $error("TDO changed without a falling edge");
  chk_bypass_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.tck_rise && st_reg.fsm == SBST_SH_DR && st_reg.ir == SBST_IR_BYPASS)
    |=> (st_reg.bypass == $past(ev.tdi)))
    else $error("bypass did not take TDI");
  chk_ir_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.ir != $past(st_reg.ir)) |->
    ($past(st_reg.fsm) == SBST_UPD_IR || $past(st_reg.fsm) == SBST_TLR))
    else $error("instruction changed outside update or reset");
  chk_id_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
    (ev.tck_rise && st_reg.fsm == SBST_CAP_DR && st_reg.ir == SBST_IR_IDREAD)
    |=> (st_reg.idr == ID_VALUE))
    else $error("identification not captured");
  // Several falls separate Update-IR from Shift-DR, so the float must be up by then
  chk_hiz_sample: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_reg.ir == SBST_IR_HIZ_SAMP && st_reg.fsm == SBST_SH_DR) |-> mem_out_hiz)
    else $error("outputs not floated in high-impedance sample");
endmodule

// ### sbst_ctl_model.sv
`timescale 1ns/100ps
module sbst_ctl_model
(
  // Clock
  input  wire logic core_clk,
  // Test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // Before the first frame tck stands low and the data pins sit at their pull-up level
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One tck period is eight core_clk cycles; tdo is read while tck is high
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (2) @(posedge core_clk);
    q  = tdo;
    oe = tdo_oe;
    repeat (2) @(posedge core_clk);
    tck <= 1'b0;
  endtask
  task automatic reset_walk();
    logic q;
    logic oe;
    repeat (5) step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
  endtask
  // From Run-Test/Idle through one scan and back
  task automatic scan(input logic ir, input int n, input logic [39:0] din,
                      output logic [39:0] dout, output logic oe_ok);
    logic q;
    logic oe;
    dout  = '0;
    oe_ok = 1'b1;
    step(1'b1, 1'b1, q, oe);
    if (ir)
      step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_ok   = oe_ok & (oe === 1'b1);
    end
    step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    oe_ok = oe_ok & (oe === 1'b0);
  endtask
endmodule

// ### sbst_tap_bench.sv
`timescale 1ns/100ps
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module sbst_tap_bench
  import sbst_pkg::*;
;
  localparam logic [7:0]  BOUND  = 8'h3F;
  localparam logic [31:0] ID_VAL = 32'h5A3C_96E1; // Arbitrary identity value
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic [7:0]  pin_levels = 8'h00;
  logic        mem_out_hiz;
  logic [7:0]  bsr_update;
  logic        extest_on;
  logic [39:0] din;
  logic [39:0] dout;
  logic        ok;
  logic [2:0]  code;
  logic [2:0]  ir_prev;
  int          seed = 57002;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #20 core_clk = ~core_clk;
  sbst_tap #(.BSR_LEN(8), .BSR_BOUND(BOUND), .ID_VALUE(ID_VAL)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_levels(pin_levels), .mem_out_hiz(mem_out_hiz),
    .bsr_update(bsr_update), .extest_on(extest_on));
  sbst_ctl_model PARTNER (
    .core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  // Unbound cells read one; unused codes fall back to the one-bit path
  function automatic logic [39:0] expect_out(input logic [2:0] c, input logic [7:0] pins,
                                             input logic [39:0] d);
    logic [7:0] cap;
    cap = (pins & BOUND) | ~BOUND;
    case (c)
      SBST_IR_EXTEST, SBST_IR_HIZ_SAMP, SBST_IR_SAMP_PRE: return {d[31:0], cap};
      SBST_IR_IDREAD: return {d[7:0], ID_VAL};
      default: return {d[38:0], 1'b0};
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    PARTNER.reset_walk();
    din = 40'({$random(seed), $random(seed)});
    PARTNER.scan(1'b0, 40, din, dout, ok);
    `CHECK(dout, expect_out(SBST_IR_IDREAD, pin_levels, din))
    ir_prev = SBST_IR_IDREAD;
    for (int c = 0; c < 8; c++)
    begin
      code = c[2:0];
      pin_levels <= (c == 0) ? 8'h00 : 8'($random(seed));
      PARTNER.scan(1'b1, 3, {37'h0, code}, dout, ok);
      `CHECK(dout[2:0], {ir_prev[2], SBST_IR_CAPTURE})
      `CHECK(ok, 1'b1)
      // Held-instruction outputs follow the next tck fall, seen a few cycles later
      repeat (4) @(posedge core_clk);
      `CHECK(mem_out_hiz, code == SBST_IR_HIZ_SAMP)
      `CHECK(extest_on, code == SBST_IR_EXTEST)
      din = 40'({$random(seed), $random(seed)});
      PARTNER.scan(1'b0, 40, din, dout, ok);
      `CHECK(dout, expect_out(code, pin_levels, din))
      `CHECK(ok, 1'b1)
      if (code == SBST_IR_EXTEST || code == SBST_IR_HIZ_SAMP || code == SBST_IR_SAMP_PRE)
        `CHECK(bsr_update, din[39:32])
      // Leave each instruction through the five-ones walk rather than a clean IR load
      PARTNER.reset_walk();
      `CHECK(mem_out_hiz | extest_on, 1'b0)
      ir_prev = SBST_IR_IDREAD;
    end
    din = 40'({$random(seed), $random(seed)});
    PARTNER.scan(1'b0, 40, din, dout, ok);
    `CHECK(dout, expect_out(SBST_IR_IDREAD, pin_levels, din))
    complete_run();
  end
endmodule
